// >>> rtl/dpg_top.sv
/*
 dpg_top: debug port, debug authentication gating, functional override
 fan-out and analyser clock-stop merge, with an AXI4-Lite register file.
 Assumes all pins and straps are asynchronous to clk_sys_in and that the
 debug port clock is far slower than clk_sys_in (sampled, not used as a
 clock). Serial trace and the bus come from logic on clk_sys_in.
*/
// Functional notes
// R1: in debug mode the serial trace bit is driven onto the data-out pin.
// R2: the SoC joins wire data in, wire data out and enable into one pad.
// R3: all debug port logic steps on the debug port clock, always-on domain; here it runs on clk_sys_in, stepped by sampled port clock edges.
// R4: separate one-bit enables per domain; application cores only invasive.
// R5: analyser disable high blocks analysers in cores and translation unit.
// R6: crypto disable high turns off crypto in every application core.
// R7: translation override high opens certain registers to non-secure.
// R8: the SoC drives each override from a fuse or secure-only register.
// R9: analyser clock-stop output is the OR of all analyser requests.
// R10: a low enable denies access; secure enables need their base enable.
`timescale 1ns/10ps
module dpg_top
    import dpg_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // AXI4-Lite slave
    input wire logic [dpg_pkg::DPG_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [dpg_pkg::DPG_AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // debug port pins
    input wire dpg_pkg::dpg_port_t port_in,
    output logic tdo_out,
    output logic jtag_reset_n_out,
    output logic wire_data_out_out,
    input wire logic serial_trace_out_in,
    // authentication and overrides
    input wire dpg_pkg::dpg_auth_t auth_in,
    output dpg_pkg::dpg_auth_t auth_eff_out,
    input wire dpg_pkg::dpg_ovr_t ovr_in,
    output logic [dpg_pkg::DPG_NUM_CORE-1:0] appcore_analyser_disable_out,
    output logic xlat_analyser_disable_out,
    output logic [dpg_pkg::DPG_NUM_CORE-1:0] appcore_crypto_disable_out,
    output logic translation_secure_override_out,
    input wire logic [dpg_pkg::DPG_NUM_ANA-1:0] analyser_clock_stop_req_in,
    output logic analyser_clock_stop_out
);
    import dpg_pkg::*;

    // three-stage sampling; a change counts once stages two and three agree
    logic [DPG_SYNC_W-1:0] raw, s1, s2, s3, filt, next_filt;

    assign raw = {port_in, auth_in, ovr_in, analyser_clock_stop_req_in};

    for (genvar gi = 0; gi < DPG_SYNC_W; gi++)
    begin : g_sync
        always_comb
        begin
            next_filt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : filt[gi];
        end

        always_ff @(posedge clk_sys_in or negedge rstn_in)
        begin
            if (!rstn_in)
            begin
                s1[gi] <= 1'b0;
                s2[gi] <= 1'b0;
                s3[gi] <= 1'b0;
                filt[gi] <= 1'b0;
            end
            else
            begin
                s1[gi] <= raw[gi];
                s2[gi] <= s1[gi];
                s3[gi] <= s2[gi];
                filt[gi] <= next_filt[gi];
            end
        end
    end

    dpg_port_t port_f;
    dpg_auth_t auth_f;
    dpg_ovr_t ovr_f;
    logic [DPG_NUM_ANA-1:0] stop_f;

    assign {port_f, auth_f, ovr_f, stop_f} = filt;

    // secure variants are meaningless without the base enable
    function automatic dpg_auth4_t dpg_gate4(input dpg_auth4_t a);
        dpg_auth4_t r;
        r.inv = a.inv;
        r.noninv = a.noninv;
        r.sec_inv = a.inv & a.sec_inv;
        r.sec_noninv = a.noninv & a.sec_noninv;
        return r;
    endfunction : dpg_gate4

    // register and bus state
    logic [1:0] ctrl, bresp, rresp;
    logic [31:0] tx_sh, rx_sh, wdata_q, rdata;
    logic aw_hold, w_hold, bvalid, rvalid, clk_q;
    logic [DPG_AW-1:0] awaddr_q;
    logic [3:0] wstrb_q;

    logic [1:0] next_ctrl, next_bresp, next_rresp;
    logic [31:0] next_tx_sh, next_rx_sh, next_wdata_q, next_rdata;
    logic next_aw_hold, next_w_hold, next_bvalid, next_rvalid, next_clk_q;
    logic [DPG_AW-1:0] next_awaddr_q;
    logic [3:0] next_wstrb_q;

    logic dbg_mode, port_rise, port_fall;
    logic [31:0] stat_word, auth_word;
    dpg_auth_t auth_eff;

    assign dbg_mode = ctrl[DPG_CTRL_DBG_MODE_BIT];
    // edges of the sampled debug port clock step the receive and transmit shifters
    assign port_rise = port_f.debug_port_clock & ~clk_q; // R3
    assign port_fall = ~port_f.debug_port_clock & clk_q; // R3

    always_comb
    begin
        auth_eff.sys = dpg_gate4(auth_f.sys); // R10
        auth_eff.ctrlproc = dpg_gate4(auth_f.ctrlproc); // R10
        auth_eff.mgmtproc = dpg_gate4(auth_f.mgmtproc); // R10
        auth_eff.appcore_inv = auth_f.appcore_inv; // R4
        auth_eff.appcore_sec_inv = auth_f.appcore_inv
            & auth_f.appcore_sec_inv; // R10
        stat_word = 32'h0;
        stat_word[DPG_STAT_ANA_DIS_BIT] = ovr_f.analyser_disable;
        stat_word[DPG_STAT_CRYPTO_BIT] = ovr_f.crypto_disable_a;
        stat_word[DPG_STAT_XLAT_BIT] = ovr_f.translation_secure_override;
        stat_word[DPG_STAT_STOP_BIT] = |stop_f;
        stat_word[DPG_STAT_WDOEN_BIT] = port_f.wire_data_out_enable;
        stat_word[DPG_STAT_MODE_BIT] = dbg_mode;
        auth_word = {18'h0, auth_eff};
    end

    assign s_axi_awready_out = ~aw_hold & ~bvalid;
    assign s_axi_wready_out = ~w_hold & ~bvalid;
    assign s_axi_arready_out = ~rvalid;
    assign s_axi_bvalid_out = bvalid;
    assign s_axi_bresp_out = bresp;
    assign s_axi_rvalid_out = rvalid;
    assign s_axi_rdata_out = rdata;
    assign s_axi_rresp_out = rresp;

    always_comb
    begin
        next_ctrl = ctrl;
        next_tx_sh = tx_sh;
        next_rx_sh = rx_sh;
        next_aw_hold = aw_hold;
        next_w_hold = w_hold;
        next_awaddr_q = awaddr_q;
        next_wdata_q = wdata_q;
        next_wstrb_q = wstrb_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_clk_q = port_f.debug_port_clock;

        // serial-wire mode samples the data/mode pin, otherwise data in
        if (port_rise)
        begin
            next_rx_sh = {rx_sh[30:0],
                dbg_mode ? port_f.wire_data_in_mode_select : port_f.tdi};
        end
        if (port_fall)
        begin
            next_tx_sh = {1'b0, tx_sh[31:1]};
        end

        if (s_axi_awvalid_in && s_axi_awready_out)
        begin
            next_aw_hold = 1'b1;
            next_awaddr_q = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out)
        begin
            next_w_hold = 1'b1;
            next_wdata_q = s_axi_wdata_in;
            next_wstrb_q = s_axi_wstrb_in;
        end
        // a software load of the shifter beats a shift in the same cycle
        if (aw_hold && w_hold)
        begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = DPG_RESP_OKAY;
            unique case (awaddr_q)
                DPG_CTRL_OFS:
                begin
                    if (wstrb_q[0])
                    begin
                        next_ctrl = wdata_q[1:0];
                    end
                end
                DPG_TX_OFS:
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if (wstrb_q[b])
                        begin
                            next_tx_sh[b*8 +: 8] = wdata_q[b*8 +: 8];
                        end
                    end
                end
                DPG_STAT_OFS, DPG_AUTH_OFS, DPG_RX_OFS:
                    next_bresp = DPG_RESP_OKAY;
                default:
                    next_bresp = DPG_RESP_SLVERR;
            endcase
        end
        if (bvalid && s_axi_bready_in)
        begin
            next_bvalid = 1'b0;
        end

        if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            next_rvalid = 1'b1;
            next_rresp = DPG_RESP_OKAY;
            unique case (s_axi_araddr_in)
                DPG_CTRL_OFS: next_rdata = {30'h0, ctrl};
                DPG_STAT_OFS: next_rdata = stat_word;
                DPG_AUTH_OFS: next_rdata = auth_word;
                DPG_RX_OFS: next_rdata = rx_sh;
                DPG_TX_OFS: next_rdata = tx_sh;
                default:
                begin
                    next_rdata = 32'h0;
                    next_rresp = DPG_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid && s_axi_rready_in)
        begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ctrl <= DPG_CTRL_RST;
            tx_sh <= DPG_TX_RST;
            rx_sh <= DPG_RX_RST;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= 2'h0;
            clk_q <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            tx_sh <= next_tx_sh;
            rx_sh <= next_rx_sh;
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            awaddr_q <= next_awaddr_q;
            wdata_q <= next_wdata_q;
            wstrb_q <= next_wstrb_q;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            clk_q <= next_clk_q;
        end
    end

    // output group: all registered
    logic next_tdo, next_wdo, next_stop;
    logic [DPG_NUM_CORE-1:0] next_core_ana, next_core_crypto;

    always_comb
    begin
        next_tdo = dbg_mode ? serial_trace_out_in : tx_sh[0]; // R1
        next_wdo = tx_sh[0];
        next_stop = |stop_f; // R9
        next_core_ana = {DPG_NUM_CORE{ovr_f.analyser_disable}}; // R5
        next_core_crypto = {DPG_NUM_CORE{ovr_f.crypto_disable_a}}; // R6
    end

    // overrides reset to the permissive-off value until straps arrive
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            tdo_out <= 1'b0;
            wire_data_out_out <= 1'b0;
            jtag_reset_n_out <= 1'b0;
            analyser_clock_stop_out <= 1'b0;
            appcore_analyser_disable_out <= '0;
            xlat_analyser_disable_out <= 1'b0;
            appcore_crypto_disable_out <= '0;
            translation_secure_override_out <= 1'b0;
            auth_eff_out <= '0;
        end
        else
        begin
            tdo_out <= next_tdo;
            wire_data_out_out <= next_wdo;
            jtag_reset_n_out <= ~ctrl[DPG_CTRL_TRST_BIT];
            analyser_clock_stop_out <= next_stop;
            appcore_analyser_disable_out <= next_core_ana;
            xlat_analyser_disable_out <= ovr_f.analyser_disable; // R5
            appcore_crypto_disable_out <= next_core_crypto;
            translation_secure_override_out <=
                ovr_f.translation_secure_override; // R7
            auth_eff_out <= auth_eff; // R4
        end
    end
endmodule : dpg_top

// >>> rtl/dpg_pkg.sv
/*
 dpg_pkg: constants, register map and carrier types of the debug port
 and override glue.
 Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
*/
package dpg_pkg;
    localparam int DPG_NUM_CORE = 4;
    localparam int DPG_NUM_ANA = 4;
    localparam int DPG_AW = 8;

    // register byte offsets
    localparam logic [7:0] DPG_CTRL_OFS = 8'h00;
    localparam logic [7:0] DPG_STAT_OFS = 8'h04;
    localparam logic [7:0] DPG_AUTH_OFS = 8'h08;
    localparam logic [7:0] DPG_RX_OFS = 8'h0c;
    localparam logic [7:0] DPG_TX_OFS = 8'h10;

    // control fields
    localparam int DPG_CTRL_DBG_MODE_BIT = 0;
    localparam int DPG_CTRL_TRST_BIT = 1;
    localparam logic [1:0] DPG_CTRL_RST = 2'h0;
    localparam logic [31:0] DPG_TX_RST = 32'h0;
    localparam logic [31:0] DPG_RX_RST = 32'h0;

    // status fields
    localparam int DPG_STAT_ANA_DIS_BIT = 0;
    localparam int DPG_STAT_CRYPTO_BIT = 1;
    localparam int DPG_STAT_XLAT_BIT = 2;
    localparam int DPG_STAT_STOP_BIT = 3;
    localparam int DPG_STAT_WDOEN_BIT = 4;
    localparam int DPG_STAT_MODE_BIT = 5;

    localparam logic [1:0] DPG_RESP_OKAY = 2'h0;
    localparam logic [1:0] DPG_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic inv;
        logic noninv;
        logic sec_inv;
        logic sec_noninv;
    } dpg_auth4_t;

    typedef struct packed {
        dpg_auth4_t sys;
        dpg_auth4_t ctrlproc;
        dpg_auth4_t mgmtproc;
        logic appcore_inv;
        logic appcore_sec_inv;
    } dpg_auth_t;

    typedef struct packed {
        logic analyser_disable;
        logic crypto_disable_a;
        logic translation_secure_override;
    } dpg_ovr_t;

    // pins of the debug port, all from outside this clock domain
    typedef struct packed {
        logic debug_port_clock;
        logic tdi;
        logic wire_data_in_mode_select;
        logic wire_data_out_enable;
    } dpg_port_t;

    localparam int DPG_SYNC_W = 4 + 14 + 3 + DPG_NUM_ANA;
endpackage : dpg_pkg

// >>> test/dpg_assertions.sv
/*
 dpg_assertions: timing checks on the glue outputs of dpg_top.
 Assumes it is bound to dpg_top and sees only its ports.
*/
`timescale 1ns/10ps
module dpg_assertions
    import dpg_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic tdo_out,
    input wire logic wire_data_out_out,
    input wire logic serial_trace_out_in,
    input wire dpg_pkg::dpg_auth_t auth_in,
    input wire dpg_pkg::dpg_auth_t auth_eff_out,
    input wire dpg_pkg::dpg_ovr_t ovr_in,
    input wire logic [DPG_NUM_CORE-1:0] appcore_analyser_disable_out,
    input wire logic xlat_analyser_disable_out,
    input wire logic [DPG_NUM_CORE-1:0] appcore_crypto_disable_out,
    input wire logic translation_secure_override_out,
    input wire logic [DPG_NUM_ANA-1:0] analyser_clock_stop_req_in,
    input wire logic analyser_clock_stop_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    // synchronisers need about five edges, so wait for six calm ones
    sequence s_ovr_calm; $stable(ovr_in) [*6]; endsequence
    sequence s_auth_calm; $stable(auth_in) [*6]; endsequence
    sequence s_req_calm; $stable(analyser_clock_stop_req_in) [*6]; endsequence
    AST_ANA_CORES: assert property (s_ovr_calm |->
        appcore_analyser_disable_out == {DPG_NUM_CORE{ovr_in[2]}})
        else $error("core analyser disable wrong");
    AST_ANA_XLAT: assert property (s_ovr_calm |->
        xlat_analyser_disable_out == ovr_in[2])
        else $error("translation unit analyser disable wrong");
    AST_CRYPTO: assert property (s_ovr_calm |->
        appcore_crypto_disable_out == {DPG_NUM_CORE{ovr_in[1]}})
        else $error("crypto disable wrong");
    AST_XLAT: assert property (s_ovr_calm |->
        translation_secure_override_out == ovr_in[0])
        else $error("translation override wrong");
    AST_STOP_OR: assert property (s_req_calm |->
        analyser_clock_stop_out == |analyser_clock_stop_req_in)
        else $error("clock stop not the OR of requests");
    AST_AUTH_BASE: assert property (s_auth_calm |->
        (auth_eff_out & 14'h3332) == (auth_in & 14'h3332))
        else $error("base enable not passed");
    // secure enables count only beside their base enable
    AST_AUTH_SEC: assert property (s_auth_calm |-> auth_eff_out ==
        (auth_in & (14'h3332 | ((auth_in >> 2) & 14'h0ccc)
        | ((auth_in >> 1) & 14'h0001))))
        else $error("secure enable not gated");
    AST_TDO_SRC: assert property (tdo_out == $past(serial_trace_out_in)
        || tdo_out == wire_data_out_out)
        else $error("tdo neither trace nor data out");
endmodule : dpg_assertions

// >>> test/dpg_debugger.sv
/*
 dpg_debugger: external debugger on the debug port pins.
 Assumes the bench calls frame(); the link clock stands low between frames.
*/
`timescale 1ns/10ps
module dpg_debugger
    import dpg_pkg::*;
(
    output dpg_pkg::dpg_port_t port_out,
    input wire logic wire_data_out_in,
    output logic [3:0] seen_out
);
    logic clk = 1'b0;
    logic tdi = 1'b0;
    logic oe = 1'b0;
    logic drv = 1'b1;
    logic pad;
    assign pad = oe ? wire_data_out_in : drv;
    assign port_out = {clk, tdi, pad, oe};
    task automatic frame(input logic [3:0] bits, input logic drive);
        int i;
        // pins move by non-blocking update so no edge races the sampler
        oe <= drive;
        for (i = 3; i >= 0; i--)
        begin
            tdi <= bits[i];
            drv <= bits[i];
            #80 clk <= 1'b1;
            #80 seen_out <= {wire_data_out_in, seen_out[3:1]};
            clk <= 1'b0;
        end
        // released lines show the inverse, not a stale copy
        #80 tdi <= ~tdi;
        drv <= ~drv;
        oe <= 1'b0;
    endtask : frame
endmodule : dpg_debugger

// >>> test/test_debug_port_and_override_glue.sv
/*
 test_debug_port_and_override_glue: self-checking bench for dpg_top.
 Assumes dpg_debugger on the pins and dpg_assertions bound below.
*/
`timescale 1ns/10ps
module test_debug_port_and_override_glue;
    import dpg_pkg::*;
    typedef struct packed {
        logic [2:0] ovr;
        logic [3:0] req;
        logic [13:0] auth;
        logic [13:0] eff;
    } dpg_row_t;
    localparam dpg_row_t ROWS [5] = '{'{3'h4, 4'h1, 14'h3fff, 14'h3fff},
        '{3'h2, 4'h8, 14'h0ccd, 14'h0000}, '{3'h1, 4'h0, 14'h1edf, 14'h1697},
        '{3'h7, 4'h6, 14'h0000, 14'h0000}, '{3'h0, 4'h0, 14'h0002, 14'h0002}};
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd, val;
    logic [3:0] ws = 4'h0, req = 4'h0, ana, cry, seen;
    logic awr, wr, bv, arr, rv, tdo, jrst_n, wdo, xana, xlat, stop;
    logic [1:0] br, rr, resp;
    logic trace = 1'b0;
    dpg_port_t port;
    dpg_auth_t auth = '0;
    dpg_auth_t eff;
    dpg_ovr_t ovr = '0;
    int miscompares = 0;
    int n_checks = 0;
    int i;
    always #10 clk_sys_in = ~clk_sys_in;
    dpg_top uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bry), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .port_in(port),
        .tdo_out(tdo), .jtag_reset_n_out(jrst_n), .wire_data_out_out(wdo),
        .serial_trace_out_in(trace), .auth_in(auth), .auth_eff_out(eff),
        .ovr_in(ovr), .appcore_analyser_disable_out(ana),
        .xlat_analyser_disable_out(xana), .appcore_crypto_disable_out(cry),
        .translation_secure_override_out(xlat),
        .analyser_clock_stop_req_in(req), .analyser_clock_stop_out(stop));
    dpg_debugger dbg (.port_out(port), .wire_data_out_in(wdo),
        .seen_out(seen));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic close_out();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_in);
        awa <= a;
        wd <= d;
        ws <= 4'hf;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 40 && bv !== 1'b1; n++)
        begin
            @(posedge clk_sys_in);
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wr)
                wv <= 1'b0;
        end
        resp = br;
        bry <= 1'b0;
        if (n == 40)
        begin
            miscompares++;
            close_out();
        end
    endtask : axw
    task automatic axr(input logic [7:0] a);
        int n;
        @(posedge clk_sys_in);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 40 && rv !== 1'b1; n++)
        begin
            @(posedge clk_sys_in);
            if (arv && arr)
                arv <= 1'b0;
        end
        val = rd;
        resp = rr;
        rry <= 1'b0;
        if (n == 40)
        begin
            miscompares++;
            close_out();
        end
    endtask : axr
    initial
    begin
        repeat (20) @(posedge clk_sys_in);
        cmp({ana, xana, cry, xlat, stop, jrst_n, eff}, 32'h0);
        rstn_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1 cmp(jrst_n, 1'b1);
        axr(DPG_CTRL_OFS);
        cmp(val, 32'h0);
        axr(DPG_TX_OFS);
        cmp(val, DPG_TX_RST);
        $display("reset test done");
        for (i = 0; i < 5; i++)
        begin
            @(posedge clk_sys_in);
            ovr <= ROWS[i].ovr;
            req <= ROWS[i].req;
            auth <= ROWS[i].auth;
            repeat (8) @(posedge clk_sys_in);
            #1 cmp({ana, xana}, {5{ROWS[i].ovr[2]}});
            cmp(cry, {4{ROWS[i].ovr[1]}});
            cmp(xlat, ROWS[i].ovr[0]);
            cmp(stop, |ROWS[i].req);
            cmp(eff, ROWS[i].eff);
            axr(DPG_STAT_OFS);
            cmp(val, {|ROWS[i].req, ROWS[i].ovr[0], ROWS[i].ovr[1],
                ROWS[i].ovr[2]});
            axr(DPG_AUTH_OFS);
            cmp(val, ROWS[i].eff);
        end
        $display("table test done");
        axr(8'h14);
        cmp(val, 32'h0);
        cmp(resp, DPG_RESP_SLVERR);
        axw(DPG_STAT_OFS, 32'hffff_ffff);
        cmp(resp, DPG_RESP_OKAY);
        axw(8'h14, 32'h0);
        cmp(resp, DPG_RESP_SLVERR);
        axw(DPG_CTRL_OFS, 32'h2);
        @(posedge clk_sys_in);
        #1 cmp(jrst_n, 1'b0);
        axr(DPG_CTRL_OFS);
        cmp(val, 32'h2);
        axr(DPG_STAT_OFS);
        cmp(val, 32'h0);
        $display("refusal test done");
        axw(DPG_TX_OFS, 32'h5);
        dbg.frame(4'hb, 1'b1);
        cmp(seen, 4'h5);
        axr(DPG_RX_OFS);
        cmp(val, 32'hb);
        axw(DPG_CTRL_OFS, 32'h1);
        trace <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1 cmp(tdo, 1'b1);
        cmp(wdo, 1'b0);
        cmp(jrst_n, 1'b1);
        @(posedge clk_sys_in);
        trace <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1 cmp(tdo, 1'b0);
        axr(DPG_STAT_OFS);
        cmp(val, 32'h1 << DPG_STAT_MODE_BIT);
        dbg.frame(4'h6, 1'b0);
        axr(DPG_RX_OFS);
        cmp(val, 32'hb6);
        $display("link test done");
        @(posedge clk_sys_in);
        ovr <= 3'h7;
        rstn_in <= 1'b0;
        @(posedge clk_sys_in);
        #1 cmp(ana, 4'h0);
        @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        #1 cmp(ana, 4'hf);
        $display("second reset test done");
        close_out();
    end
endmodule : test_debug_port_and_override_glue
bind dpg_top dpg_assertions chk (.clk_sys_in, .rstn_in, .tdo_out,
    .wire_data_out_out, .serial_trace_out_in, .auth_in, .auth_eff_out,
    .ovr_in, .appcore_analyser_disable_out, .xlat_analyser_disable_out,
    .appcore_crypto_disable_out, .translation_secure_override_out,
    .analyser_clock_stop_req_in, .analyser_clock_stop_out);
